// ### tb/afp_assertions.sv
// assertion checker for the autofocus paxel configuration block
`timescale 1ns/10ps
module afp_checker (
    input wire        clock,
    input wire        rst,
    input wire [7:0]  addr,
    input wire [31:0] wr_data,
    input wire        wr_en,
    input wire        rd_en,
    input wire [31:0] rd_data_q,
    input wire        pix_valid,
    input wire        focus_engine_enable_q,
    input wire        focus_companding_enable_q,
    input wire        focus_median_enable_q,
    input wire [7:0]  median_threshold_q,
    input wire [2:0]  pattern_position_select_q,
    input wire        pattern_custom_q,
    input wire        pattern_rb_first_q,
    input wire        pattern_reserved_q,
    input wire        af_pix_valid_q,
    input wire        af_in_paxel_q,
    input wire        af_valid_region_q,
    input wire        af_iir_clear_q
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_custom_code: assert property (
        pattern_custom_q == ($past(pattern_position_select_q) inside {3'h4, 3'h5}))
        else $error("custom pattern flag wrong");
    chk_rb_first: assert property (
        pattern_rb_first_q == ($past(pattern_position_select_q) == 3'h5))
        else $error("rb first flag wrong");
    chk_reserved_code: assert property (
        pattern_reserved_q == ($past(pattern_position_select_q) >= 3'h6))
        else $error("reserved pattern flag wrong");
    chk_engine_write: assert property (
        wr_en && addr == 8'h00 |=> focus_engine_enable_q == $past(wr_data[0]))
        else $error("engine enable not stored");
    chk_alaw_write: assert property (
        wr_en && addr == 8'h00 |=> focus_companding_enable_q == $past(wr_data[1]))
        else $error("companding enable not stored");
    chk_thresh_write: assert property (
        wr_en && addr == 8'h00 |=> median_threshold_q == $past(wr_data[10:3]))
        else $error("threshold not stored");
    chk_ctrl_read: assert property (
        rd_en && addr == 8'h00 |=> rd_data_q[10:0] == {$past(median_threshold_q),
        $past(focus_median_enable_q), $past(focus_companding_enable_q),
        $past(focus_engine_enable_q)})
        else $error("control readback wrong");
    chk_pix_source: assert property (
        af_pix_valid_q |-> $past(pix_valid, 2))
        else $error("strobe without a pixel");
    chk_engine_off: assert property (
        !focus_engine_enable_q [*3] |-> !af_pix_valid_q && !af_in_paxel_q && !af_iir_clear_q)
        else $error("activity with engine off");
    chk_valid_gate: assert property (
        af_in_paxel_q |-> af_valid_region_q && af_pix_valid_q)
        else $error("paxel pixel outside valid region");
    chk_iir_gate: assert property (
        af_iir_clear_q |-> af_pix_valid_q)
        else $error("filter clear without pixel");

    cover property (af_in_paxel_q);
    cover property (af_iir_clear_q);
    cover property (pattern_reserved_q);
endmodule

bind afp_top afp_checker u_chk (.*);

// ### tb/test_afp_top.sv
// self-checking bench for the autofocus paxel configuration block
`timescale 1ns/10ps
module test_afp_top;
    // ----
    // design signals
    // ----
    logic        clock;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic        pix_valid;
    logic        line_start;
    logic        frame_start;
    logic [11:0] line_width;
    wire  [31:0] rd_data_q;
    wire         focus_engine_enable_q;
    wire         focus_companding_enable_q;
    wire         focus_median_enable_q;
    wire  [7:0]  median_threshold_q;
    wire  [2:0]  pattern_position_select_q;
    wire         pattern_custom_q;
    wire         pattern_rb_first_q;
    wire         pattern_reserved_q;
    wire         af_pix_valid_q;
    wire         af_in_paxel_q;
    wire  [5:0]  af_paxel_col_q;
    wire  [6:0]  af_paxel_row_q;
    wire         af_valid_region_q;
    wire         af_iir_clear_q;
    int          failures = 0;
    int          check_count = 0;
    int          i;
    int          n;
    int          x;
    int          y;
    logic        ex;
    logic        ip;
    logic [31:0] v;
    logic [71:0] rows [0:9];

    afp_top uut (.*);

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ----
    // tasks
    // ----
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        v = rd_data_q;
    endtask

    // waits a bounded span for the delayed strobe; engine off leaves it low
    task pix(input int px, input int py);
        @(posedge clock);
        pix_valid   <= 1'b1;
        line_start  <= (px == 0);
        frame_start <= (px == 0 && py == 0);
        @(posedge clock);
        pix_valid   <= 1'b0;
        line_start  <= 1'b0;
        frame_start <= 1'b0;
        n = 0;
        while (af_pix_valid_q !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    task done(input string s);
        $display("test %s done", s);
    endtask

    task print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(25 * 6000);
        failures++;
        print_verdict;
    end

    // ----
    // main sequence
    // ----
    initial begin
        rows = '{
            {8'h00, 32'hffffffff, 32'h00003fff}, {8'h04, 32'hffffffff, 32'h007f007f},
            {8'h08, 32'hffffffff, 32'h0001ffff}, {8'h0c, 32'hffffffff, 32'h0fff0fff},
            {8'h10, 32'hffffffff, 32'h00000fff}, {8'h18, 32'hffffffff, 32'h00000000},
            {8'h00, 32'ha5a5a5a5, 32'h000025a5}, {8'h04, 32'ha5a5a5a5, 32'h00250025},
            {8'h08, 32'ha5a5a5a5, 32'h0001a5a5}, {8'h0c, 32'ha5a5a5a5, 32'h05a505a5}};
        rst = 1'b1;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        pix_valid = 1'b0;
        line_start = 1'b0;
        frame_start = 1'b0;
        line_width = 12'h014;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 10; i++) begin
            wr(rows[i][71:64], rows[i][63:32]);
            rd(rows[i][71:64]);
            chk(v, rows[i][31:0], "readback");
        end
        done("register rows");
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        rd(8'h00);
        chk(v, 32'h000007f8, "ctrl reset");
        rd(8'h0c);
        chk(v, 32'h0, "start reset");
        done("reset");
        for (i = 0; i < 8; i++) begin
            wr(8'h00, i << 11);
            @(posedge clock);
            @(posedge clock);
            #1;
            chk({pattern_reserved_q, pattern_rb_first_q, pattern_custom_q},
                {i >= 6, i == 5, i == 4 || i == 5}, "pattern");
            chk(pattern_position_select_q, i, "pattern field");
        end
        done("pattern codes");
        // width 6, height 4, two by two paxels, every other pair, start (4,1)
        wr(8'h04, 32'h00020001);
        wr(8'h08, 32'h00002041);
        wr(8'h0c, 32'h00040001);
        wr(8'h10, 32'h00000002);
        wr(8'h00, 32'h000007fd);
        #1;
        chk({focus_median_enable_q, focus_companding_enable_q, focus_engine_enable_q}, 3'h5,
            "ctrl outputs");
        for (y = 0; y < 10; y++)
            for (x = 0; x < 20; x++) begin
                pix(x, y);
                ex = x >= 2 && x <= 17;
                ip = ex && x >= 4 && x <= 15 && y >= 1 && y <= 8 && ((y - 1) % 4) < 2;
                chk(af_pix_valid_q, 1, "strobe");
                chk(af_valid_region_q, ex, "region");
                chk(af_in_paxel_q, ip, "in paxel");
                chk(af_iir_clear_q, x == 3, "clear");
                if (ip)
                    chk({af_paxel_row_q, af_paxel_col_q},
                        {7'((y - 1) / 4), 6'((x - 4) / 6)}, "index");
            end
        rd(8'h14);
        chk(v, 32'h00090013, "status");
        done("frame walk");
        wr(8'h00, 32'h00000000);
        pix(0, 0);
        chk(af_pix_valid_q, 0, "engine off");
        chk(median_threshold_q, 8'h00, "threshold zero");
        wr(8'h00, 32'h00000002);
        #1;
        chk({focus_companding_enable_q, focus_engine_enable_q}, 2'h2, "alaw");
        done("engine off");
        print_verdict;
    end
endmodule

// ### verilog/afp_axis.v
// one axis of the paxel grid: position, paxel index and offset inside a paxel
`timescale 1ns/10ps
module afp_axis (
    input  wire        clock,
    input  wire        rst,
    input  wire        restart,
    input  wire        advance,
    input  wire [11:0] start,
    input  wire [6:0]  size_field,
    input  wire [6:0]  count_field,
    output reg  [11:0] pos_q,
    output reg         inside_q,
    output reg  [6:0]  idx_q,
    output reg  [7:0]  offs_q
);
    reg [11:0] pos_d;
    reg        inside_d;
    reg [6:0]  idx_d;
    reg [7:0]  offs_d;

    // ----------------------------------------
    // next position
    // ----------------------------------------
    always @* begin
        pos_d    = pos_q;
        inside_d = inside_q;
        idx_d    = idx_q;
        offs_d   = offs_q;
        if (restart || advance) begin
            pos_d = restart ? 12'h000 : pos_q + 12'h001;
            if (restart) begin
                inside_d = 1'b0;
            end
            if (pos_d == start) begin
                inside_d = 1'b1;
                idx_d    = 7'h00;
                offs_d   = 8'h00;
            end else if (inside_q && !restart) begin
                // last offset is size*2+1, i.e. the field with a one appended
                if (offs_q == {size_field, 1'b1}) begin
                    offs_d = 8'h00;
                    if (idx_q == count_field) begin
                        inside_d = 1'b0;
                    end else begin
                        idx_d = idx_q + 7'h01;
                    end
                end else begin
                    offs_d = offs_q + 8'h01;
                end
            end
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pos_q    <= 12'h000;
            inside_q <= 1'b0;
            idx_q    <= 7'h00;
            offs_q   <= 8'h00;
        end else begin
            pos_q    <= pos_d;
            inside_q <= inside_d;
            idx_q    <= idx_d;
            offs_q   <= offs_d;
        end
    end
endmodule

// ### verilog/afp_regs.vh
// constants for the autofocus paxel configuration block
// Notes on behaviour
// - pattern code 4h selects a custom GG-then-RB layout, 5h a custom RB-then-GG layout, 6h-7h are reserved.
// - with the median filter on, the first two and last two pixels of a line are outside the valid region.
// - the median threshold is the 8-bit field in bits 10 to 3 of the control register, 0 to ffh.
// - control bit 1 set enables the focus companding table, cleared disables it.
// - control bit 0 set enables the focus engine, cleared disables it.
// - paxel width is (width field in bits 22-16 plus one) times two pixels, at least 6 by software.
// - paxel height is (height field in bits 6-0 plus one) times two lines, even values 2 to 256.
// - lines inside a paxel advance by pairs, stepping (increment field plus one) pairs at a time.
// - the first line pair of every paxel is always processed before the increment applies.
// - the vertical paxel count field is paxels minus one, no more than 128 paxels in total.
// - the horizontal paxel count field is paxels minus one, never programmed above 35.
// - the first paxel row begins on the line given by the vertical start field in bits 11-0.
// - the pixel after the one whose position equals the filter start clears the filter state.
`ifndef AFP_REGS_VH
`define AFP_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define AFP_OFS_CTRL    8'h00
`define AFP_OFS_SIZE    8'h04
`define AFP_OFS_GRID    8'h08
`define AFP_OFS_START   8'h0c
`define AFP_OFS_FSTART  8'h10
`define AFP_OFS_STATUS  8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define AFP_CTL_EN      0
`define AFP_CTL_ALAW    1
`define AFP_CTL_MED     2
`define AFP_CTL_TH_LSB  3
`define AFP_CTL_TH_MSB  10
`define AFP_CTL_POS_LSB 11
`define AFP_CTL_POS_MSB 13
`define AFP_WDTH_LSB    16
`define AFP_WDTH_MSB    22
`define AFP_HGHT_LSB    0
`define AFP_HGHT_MSB    6
`define AFP_INC_LSB     13
`define AFP_INC_MSB     16
`define AFP_VC_LSB      6
`define AFP_VC_MSB      12
`define AFP_HC_LSB      0
`define AFP_HC_MSB      5
`define AFP_SH_LSB      16
`define AFP_SH_MSB      27
`define AFP_SV_LSB      0
`define AFP_SV_MSB      11
`define AFP_FS_LSB      0
`define AFP_FS_MSB      11

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define AFP_TH_RST      8'hff
`define AFP_PAT_GG_RB   3'h4
`define AFP_PAT_RB_GG   3'h5
`define AFP_MED_MARGIN  12'h002

`endif

// ### verilog/afp_top.v
// autofocus paxel configuration registers and the pixel walker they steer
`timescale 1ns/10ps
`include "afp_regs.vh"
module afp_top (
    input  wire        clock,
    input  wire        rst,
    input  wire [7:0]  addr,
    input  wire [31:0] wr_data,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rd_data_q,
    input  wire        pix_valid,
    input  wire        line_start,
    input  wire        frame_start,
    input  wire [11:0] line_width,
    output reg         focus_engine_enable_q,
    output reg         focus_companding_enable_q,
    output reg         focus_median_enable_q,
    output reg  [7:0]  median_threshold_q,
    output reg  [2:0]  pattern_position_select_q,
    output reg         pattern_custom_q,
    output reg         pattern_rb_first_q,
    output reg         pattern_reserved_q,
    output reg         af_pix_valid_q,
    output reg         af_in_paxel_q,
    output reg  [5:0]  af_paxel_col_q,
    output reg  [6:0]  af_paxel_row_q,
    output reg         af_valid_region_q,
    output reg         af_iir_clear_q
);
    // ----------------------------------------
    // configuration storage
    // ----------------------------------------
    reg [6:0]  paxel_width_field_q;
    reg [6:0]  paxel_height_field_q;
    reg [3:0]  line_increment_field_q;
    reg [6:0]  vertical_paxel_count_q;
    reg [5:0]  horizontal_paxel_count_q;
    reg [11:0] paxel_horizontal_start_q;
    reg [11:0] paxel_vertical_start_q;
    reg [11:0] filter_horizontal_start_q;

    // ----------------------------------------
    // walker state
    // ----------------------------------------
    reg        pix1_q;
    reg        line_new1_q;
    reg [3:0]  skip_q;
    reg [3:0]  skip_now;
    reg        iir_arm_q;
    reg        row_take;
    reg        edge_ok;

    wire [11:0] h_pos;
    wire        h_inside;
    wire [6:0]  h_idx;
    wire [7:0]  h_offs;
    wire [11:0] v_pos;
    wire        v_inside;
    wire [6:0]  v_idx;
    wire [7:0]  v_offs;

    wire        h_restart;
    wire        v_restart;
    wire        v_advance;
    wire [11:0] edge_hi;

    // ----------------------------------------
    // walker strobes
    // ----------------------------------------
    // a frame start restarts the frame axis instead of stepping it
    // the line axis steps on every pixel, the frame axis once per line
    assign h_restart = pix_valid & line_start;
    assign v_restart = pix_valid & frame_start;
    assign v_advance = pix_valid & line_start & ~frame_start;
    // last pixel index that keeps two pixels of margin at the line end
    assign edge_hi   = line_width - `AFP_MED_MARGIN - 12'h001;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            focus_engine_enable_q     <= 1'b0;
            focus_companding_enable_q <= 1'b0;
            focus_median_enable_q     <= 1'b0;
            median_threshold_q        <= `AFP_TH_RST;
            pattern_position_select_q <= 3'h0;
            paxel_width_field_q       <= 7'h00;
            paxel_height_field_q      <= 7'h00;
            line_increment_field_q    <= 4'h0;
            vertical_paxel_count_q    <= 7'h00;
            horizontal_paxel_count_q  <= 6'h00;
            paxel_horizontal_start_q  <= 12'h000;
            paxel_vertical_start_q    <= 12'h000;
            filter_horizontal_start_q <= 12'h000;
        end else if (wr_en) begin
            // reserved bits are dropped here, so readback never shows them
            case (addr)
                `AFP_OFS_CTRL: begin
                    focus_engine_enable_q     <= wr_data[`AFP_CTL_EN];
                    focus_companding_enable_q <= wr_data[`AFP_CTL_ALAW];
                    focus_median_enable_q     <= wr_data[`AFP_CTL_MED];
                    median_threshold_q <= wr_data[`AFP_CTL_TH_MSB:`AFP_CTL_TH_LSB];
                    pattern_position_select_q <=
                        wr_data[`AFP_CTL_POS_MSB:`AFP_CTL_POS_LSB];
                end
                `AFP_OFS_SIZE: begin
                    paxel_width_field_q  <= wr_data[`AFP_WDTH_MSB:`AFP_WDTH_LSB];
                    paxel_height_field_q <= wr_data[`AFP_HGHT_MSB:`AFP_HGHT_LSB];
                end
                `AFP_OFS_GRID: begin
                    line_increment_field_q   <= wr_data[`AFP_INC_MSB:`AFP_INC_LSB];
                    vertical_paxel_count_q   <= wr_data[`AFP_VC_MSB:`AFP_VC_LSB];
                    horizontal_paxel_count_q <= wr_data[`AFP_HC_MSB:`AFP_HC_LSB];
                end
                `AFP_OFS_START: begin
                    paxel_horizontal_start_q <= wr_data[`AFP_SH_MSB:`AFP_SH_LSB];
                    paxel_vertical_start_q   <= wr_data[`AFP_SV_MSB:`AFP_SV_LSB];
                end
                `AFP_OFS_FSTART: begin
                    filter_horizontal_start_q <= wr_data[`AFP_FS_MSB:`AFP_FS_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    // unmapped offsets and reserved bits read as zero
    // reads have no side effects, so polling status is safe
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_q <= 32'h00000000;
        end else if (rd_en) begin
            rd_data_q <= 32'h00000000;
            case (addr)
                `AFP_OFS_CTRL: begin
                    rd_data_q[`AFP_CTL_EN]   <= focus_engine_enable_q;
                    rd_data_q[`AFP_CTL_ALAW] <= focus_companding_enable_q;
                    rd_data_q[`AFP_CTL_MED]  <= focus_median_enable_q;
                    rd_data_q[`AFP_CTL_TH_MSB:`AFP_CTL_TH_LSB] <= median_threshold_q;
                    rd_data_q[`AFP_CTL_POS_MSB:`AFP_CTL_POS_LSB] <=
                        pattern_position_select_q;
                end
                `AFP_OFS_SIZE: begin
                    rd_data_q[`AFP_WDTH_MSB:`AFP_WDTH_LSB] <= paxel_width_field_q;
                    rd_data_q[`AFP_HGHT_MSB:`AFP_HGHT_LSB] <= paxel_height_field_q;
                end
                `AFP_OFS_GRID: begin
                    rd_data_q[`AFP_INC_MSB:`AFP_INC_LSB] <= line_increment_field_q;
                    rd_data_q[`AFP_VC_MSB:`AFP_VC_LSB]   <= vertical_paxel_count_q;
                    rd_data_q[`AFP_HC_MSB:`AFP_HC_LSB]   <= horizontal_paxel_count_q;
                end
                `AFP_OFS_START: begin
                    rd_data_q[`AFP_SH_MSB:`AFP_SH_LSB] <= paxel_horizontal_start_q;
                    rd_data_q[`AFP_SV_MSB:`AFP_SV_LSB] <= paxel_vertical_start_q;
                end
                `AFP_OFS_FSTART: begin
                    rd_data_q[`AFP_FS_MSB:`AFP_FS_LSB] <= filter_horizontal_start_q;
                end
                `AFP_OFS_STATUS: begin
                    // live walker position, the line in the upper half
                    // a snapshot only: it moves with every pixel strobe
                    rd_data_q[27:16] <= v_pos;
                    rd_data_q[11:0]  <= h_pos;
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // pattern decode
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pattern_custom_q   <= 1'b0;
            pattern_rb_first_q <= 1'b0;
            pattern_reserved_q <= 1'b0;
        end else begin
            pattern_custom_q   <= (pattern_position_select_q == `AFP_PAT_GG_RB) ||
                                  (pattern_position_select_q == `AFP_PAT_RB_GG);
            pattern_rb_first_q <= (pattern_position_select_q == `AFP_PAT_RB_GG);
            // codes 6h and 7h are flagged; the datapath must not trust them
            pattern_reserved_q <= pattern_position_select_q[2] &
                                  pattern_position_select_q[1];
        end
    end

    // ----------------------------------------
    // horizontal axis
    // ----------------------------------------
    afp_axis u_haxis (
        .clock       (clock),
        .rst         (rst),
        .restart     (h_restart),
        .advance     (pix_valid),
        .start       (paxel_horizontal_start_q),
        .size_field  (paxel_width_field_q),
        .count_field ({1'b0, horizontal_paxel_count_q}),
        .pos_q       (h_pos),
        .inside_q    (h_inside),
        .idx_q       (h_idx),
        .offs_q      (h_offs)
    );

    // ----------------------------------------
    // vertical axis
    // ----------------------------------------
    afp_axis u_vaxis (
        .clock       (clock),
        .rst         (rst),
        .restart     (v_restart),
        .advance     (v_advance),
        .start       (paxel_vertical_start_q),
        .size_field  (paxel_height_field_q),
        .count_field (vertical_paxel_count_q),
        .pos_q       (v_pos),
        .inside_q    (v_inside),
        .idx_q       (v_idx),
        .offs_q      (v_offs)
    );

    // ----------------------------------------
    // line pair selection
    // ----------------------------------------
    // skip counts pairs since the last processed pair; zero means take this pair
    // odd offsets are the second line of a pair and keep the choice already made
    always @* begin
        skip_now = skip_q;
        if (line_new1_q) begin
            if (v_offs == 8'h00) begin
                skip_now = 4'h0;
            end else if (!v_offs[0]) begin
                skip_now = (skip_q == line_increment_field_q) ? 4'h0
                                                              : skip_q + 4'h1;
            end
        end
        row_take = v_inside && (skip_now == 4'h0);
    end

    // ----------------------------------------
    // median margin
    // ----------------------------------------
    // margins are per line; the top and bottom lines are not trimmed
    always @* begin
        edge_ok = 1'b1;
        if (focus_median_enable_q) begin
            edge_ok = (h_pos >= `AFP_MED_MARGIN) && (h_pos <= edge_hi);
        end
    end

    // ----------------------------------------
    // pixel stage
    // ----------------------------------------
    // the axes answer one cycle after the strobe; this stage lines up with them
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pix1_q      <= 1'b0;
            line_new1_q <= 1'b0;
            skip_q      <= 4'h0;
            iir_arm_q   <= 1'b0;
        end else begin
            pix1_q      <= pix_valid;
            line_new1_q <= pix_valid & line_start;
            skip_q      <= skip_now;
            // the arm holds across gaps, so a match on a line end fires on the next pixel
            if (pix1_q) begin
                iir_arm_q <= (h_pos == filter_horizontal_start_q);
            end
        end
    end

    // ----------------------------------------
    // output stage
    // ----------------------------------------
    // registered so the datapath sees no path from the bus or the pixel pins
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            af_pix_valid_q    <= 1'b0;
            af_in_paxel_q     <= 1'b0;
            af_paxel_col_q    <= 6'h00;
            af_paxel_row_q    <= 7'h00;
            af_valid_region_q <= 1'b0;
            af_iir_clear_q    <= 1'b0;
        end else begin
            af_pix_valid_q    <= pix1_q & focus_engine_enable_q;
            af_in_paxel_q     <= pix1_q & focus_engine_enable_q & h_inside &
                                 row_take & edge_ok;
            af_paxel_col_q    <= h_idx[5:0];
            af_paxel_row_q    <= v_idx;
            af_valid_region_q <= pix1_q & edge_ok;
            // clear on the pixel that follows the matching position
            af_iir_clear_q    <= pix1_q & iir_arm_q & focus_engine_enable_q;
        end
    end
endmodule
